// file: pkg/tec_pkg.sv
`default_nettype none
package tec_pkg;
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned SEC_MS = 1000;
	localparam int unsigned T1_UPD_MS = 42;
	localparam int unsigned E1_UPD_MS = 62;
	localparam int unsigned SEC_CYC = SEC_MS * CLK_KHZ;
	localparam int unsigned T1_UPD_CYC = T1_UPD_MS * CLK_KHZ;
	localparam int unsigned E1_UPD_CYC = E1_UPD_MS * CLK_KHZ;
	localparam int unsigned TMR_W = 27;
	localparam int unsigned T1_EXZ_RUN = 16;
	localparam int unsigned T1_EXZ_RUN_SUB = 8;
	localparam int unsigned ZRUN_W = 5;
	localparam logic [3:0] A_CFG = 4'h0;
	localparam logic [3:0] A_MODE = 4'h1;
	localparam logic [3:0] A_CMD = 4'h2;
	localparam logic [3:0] A_STAT = 4'h3;
	localparam logic [3:0] A_LINE_HI = 4'h4;
	localparam logic [3:0] A_LINE_LO = 4'h5;
	localparam logic [3:0] A_PATH_HI = 4'h6;
	localparam logic [3:0] A_PATH_LO = 4'h7;
	localparam logic [3:0] A_SYNC_HI = 4'h8;
	localparam logic [3:0] A_SYNC_LO = 4'h9;
	localparam logic [3:0] A_FEBE_HI = 4'hA;
	localparam logic [3:0] A_FEBE_LO = 4'hB;
	localparam int unsigned CFG_EXZ = 0;
	localparam int unsigned CFG_SYNC_SRC = 1;
	localparam int unsigned CFG_FS = 2;
	localparam int unsigned CFG_E1_CV = 3;
	localparam int unsigned CFG_UPD_LSB = 4;
	localparam int unsigned MODE_E1 = 0;
	localparam int unsigned MODE_ESF = 1;
	localparam int unsigned MODE_B8ZS = 2;
	localparam int unsigned MODE_HDB3 = 3;
	localparam int unsigned MODE_CRC4 = 4;
	localparam int unsigned CMD_UPDATE = 0;
	localparam int unsigned CMD_RESYNC = 1;
	localparam int unsigned STAT_RECEIVE_LOSS_OF_SYNC = 0;
	localparam int unsigned STAT_UPD = 1;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam int unsigned N_CNT = 4;
	localparam int unsigned C_LINE = 0;
	localparam int unsigned C_PATH = 1;
	localparam int unsigned C_SYNC = 2;
	localparam int unsigned C_FEBE = 3;
	typedef enum logic [1:0]
	{
		UPD_SEC = 2'h0,
		UPD_SHORT = 2'h1,
		UPD_MANUAL = 2'h2
	} tec_upd_t;
endpackage
`default_nettype wire

// file: rtl/tec_error_counters.sv
// Notes on behaviour
// - Snapshot counts at second, 42/62ms or manual.
// - Counters saturate, never wrap.
// - T1 line counter ignores loss of sync.
// - T1 line: BPVs, optional 16/8 zero runs.
// - E1 BPV is equal-polarity marks, minus HDB3.
// - E1 select bit picks BPVs or CVs.
// - E1 line counter ignores sync, holds 65535.
// - T1 path: CRC6 in ESF, Ft/Fs in D4.
// - T1 path counter halts during loss of sync.
// - E1 path counter counts CRC4 block errors.
// - E1 path/E-bit halt on FAS/CRC4 loss only.
// - Path count is two halves, high first.
// - T1 sync counter: lost multiframes or F-bit errors.
// - T1 multiframe mode counts only in loss of sync; F-bit mode halts.
// - E1 sync counter: FAS word errors, halts in loss.
// - E1 FAS errors ignored during alignment search.
// - Sync count is two halves, high first.
// - E1 CRC4 E-bit zero counts one error.
// - E-bit count is two halves, high first.
// - Loss of sync at reset, resync, manual request.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tec_error_counters
#(
	parameter int unsigned UPD_SEC_CYC = tec_pkg::SEC_CYC,
	parameter int unsigned UPD_T1_CYC  = tec_pkg::T1_UPD_CYC,
	parameter int unsigned UPD_E1_CYC  = tec_pkg::E1_UPD_CYC
)
(
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       bit_valid_i,
	input  wire logic       mark_i,
	input  wire logic       mark_positive_i,
	input  wire logic       substitution_bit_i,
	input  wire logic       crc6_error_i,
	input  wire logic       ft_error_i,
	input  wire logic       fs_error_i,
	input  wire logic       fps_error_i,
	input  wire logic       multiframe_tick_i,
	input  wire logic       crc4_error_i,
	input  wire logic       fas_word_error_i,
	input  wire logic       fas_sync_lost_i,
	input  wire logic       crc4_sync_lost_i,
	input  wire logic       fas_search_i,
	input  wire logic       cas_mf_search_i,
	input  wire logic       crc4_mf_search_i,
	input  wire logic       ebit_strobe_i,
	input  wire logic       ebit_i,
	input  wire logic       resync_criteria_i,
	input  wire logic       sync_found_i,
	output logic            receive_loss_of_sync_o,
	output logic            update_flag_o
);

	typedef struct packed
	{
		logic [7:0]                          error_counter_config;
		logic [7:0]                          mode;
		logic                                receive_loss_of_sync;
		logic                                upd_flag;
		logic [tec_pkg::TMR_W-1:0]           tmr;
		logic [tec_pkg::N_CNT-1:0][15:0]     run;
		logic [tec_pkg::N_CNT-1:0][15:0]     snap;
		logic                                mark_seen;
		logic                                last_mark_pos;
		logic                                viol_seen;
		logic                                last_viol_pos;
		logic [tec_pkg::ZRUN_W-1:0]          zrun;
		logic [7:0]                          rdata;
	} tec_state_t;

	logic       rst_meta_r;
	logic       rst_n_r;
	tec_state_t st_r;
	tec_state_t st_nxt;

	// The reset is released through two flops so every state flop leaves reset on the same edge.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	logic                         is_e1;
	logic                         is_esf;
	logic                         sub_en;
	logic                         bpv_raw;
	logic                         bpv;
	logic                         cv;
	logic                         exz_hit;
	logic [tec_pkg::ZRUN_W-1:0]   exz_len;
	logic                         line_evt;
	logic                         path_evt;
	logic                         sync_evt;
	logic                         febe_evt;
	logic                         e1_frame_ok;
	logic [tec_pkg::N_CNT-1:0]    evt;
	logic [1:0]                   upd_mode;
	logic [tec_pkg::TMR_W-1:0]    tmr_last;
	logic                         tmr_hit;
	logic                         upd;
	logic                         wr_cmd;
	logic                         rd_sel;

	always_comb
	begin
		is_e1  = st_r.mode[tec_pkg::MODE_E1];
		is_esf = st_r.mode[tec_pkg::MODE_ESF];
		sub_en = is_e1 ? st_r.mode[tec_pkg::MODE_HDB3] : st_r.mode[tec_pkg::MODE_B8ZS];

		// A violation is a mark of the same polarity as the previous mark.
		bpv_raw = bit_valid_i && mark_i && st_r.mark_seen
			&& (mark_positive_i == st_r.last_mark_pos);
		// Violations inside a substitution word are part of the code, not errors.
		bpv = bpv_raw && !(sub_en && substitution_bit_i);
		// A code violation repeats the polarity of the previous violation.
		cv = bpv_raw && st_r.viol_seen && (mark_positive_i == st_r.last_viol_pos);

		exz_len = st_r.mode[tec_pkg::MODE_B8ZS] ? tec_pkg::ZRUN_W'(tec_pkg::T1_EXZ_RUN_SUB)
			: tec_pkg::ZRUN_W'(tec_pkg::T1_EXZ_RUN);
		// One count per zero run; the run length holds until the next mark.
		exz_hit = bit_valid_i && !mark_i && (st_r.zrun == exz_len - tec_pkg::ZRUN_W'(1));

		if (is_e1)
		begin
			line_evt = st_r.error_counter_config[tec_pkg::CFG_E1_CV] ? cv : bpv;
		end
		else
		begin
			line_evt = bpv || (st_r.error_counter_config[tec_pkg::CFG_EXZ] && exz_hit);
		end

		// CAS multiframe loss deliberately plays no part here.
		e1_frame_ok = !fas_sync_lost_i && !crc4_sync_lost_i;

		if (is_e1)
		begin
			path_evt = e1_frame_ok && crc4_error_i;
		end
		else if (is_esf)
		begin
			path_evt = !st_r.receive_loss_of_sync && crc6_error_i;
		end
		else
		begin
			path_evt = !st_r.receive_loss_of_sync && (ft_error_i
				|| (st_r.error_counter_config[tec_pkg::CFG_FS] && fs_error_i));
		end

		if (is_e1)
		begin
			sync_evt = !st_r.receive_loss_of_sync && !fas_search_i && !cas_mf_search_i && !crc4_mf_search_i
				&& fas_word_error_i;
		end
		else if (st_r.error_counter_config[tec_pkg::CFG_SYNC_SRC])
		begin
			sync_evt = !st_r.receive_loss_of_sync && (is_esf ? fps_error_i : ft_error_i);
		end
		else
		begin
			sync_evt = st_r.receive_loss_of_sync && multiframe_tick_i;
		end

		febe_evt = is_e1 && st_r.mode[tec_pkg::MODE_CRC4] && e1_frame_ok
			&& ebit_strobe_i && !ebit_i;

		evt[tec_pkg::C_LINE] = line_evt;
		evt[tec_pkg::C_PATH] = path_evt;
		evt[tec_pkg::C_SYNC] = sync_evt;
		evt[tec_pkg::C_FEBE] = febe_evt;

		upd_mode = st_r.error_counter_config[tec_pkg::CFG_UPD_LSB +: 2];
		if (upd_mode == tec_pkg::UPD_SEC)
		begin
			tmr_last = tec_pkg::TMR_W'(UPD_SEC_CYC - 1);
		end
		else if (is_e1)
		begin
			tmr_last = tec_pkg::TMR_W'(UPD_E1_CYC - 1);
		end
		else
		begin
			tmr_last = tec_pkg::TMR_W'(UPD_T1_CYC - 1);
		end
		tmr_hit = (st_r.tmr == tmr_last);
		wr_cmd  = reg_wr_i && (reg_addr_i == tec_pkg::A_CMD);
		// Codes above manual also behave as manual, so no automatic update is ever surprising.
		upd = (tmr_hit && (upd_mode == tec_pkg::UPD_SEC || upd_mode == tec_pkg::UPD_SHORT))
			|| (wr_cmd && reg_wdata_i[tec_pkg::CMD_UPDATE]);
		rd_sel = reg_rd_i;

		st_nxt = st_r;

		st_nxt.tmr = (tmr_hit || upd) ? '0 : st_r.tmr + tec_pkg::TMR_W'(1);

		if (bit_valid_i && mark_i)
		begin
			st_nxt.mark_seen     = 1'b1;
			st_nxt.last_mark_pos = mark_positive_i;
			st_nxt.zrun          = '0;
		end
		else if (bit_valid_i && st_r.zrun != exz_len)
		begin
			st_nxt.zrun = st_r.zrun + tec_pkg::ZRUN_W'(1);
		end
		if (bpv_raw)
		begin
			st_nxt.viol_seen     = 1'b1;
			st_nxt.last_viol_pos = mark_positive_i;
		end

		for (int i = 0; i < tec_pkg::N_CNT; i++)
		begin
			if (upd)
			begin
				// The event of the update cycle opens the new interval, so none is lost.
				st_nxt.snap[i] = st_r.run[i];
				st_nxt.run[i]  = {15'h0000, evt[i]};
			end
			else if (evt[i] && st_r.run[i] != tec_pkg::CNT_MAX)
			begin
				st_nxt.run[i] = st_r.run[i] + 16'h0001;
			end
		end

		if (reg_wr_i && reg_addr_i == tec_pkg::A_CFG)
		begin
			st_nxt.error_counter_config = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == tec_pkg::A_MODE)
		begin
			st_nxt.mode = reg_wdata_i;
		end

		// Set wins over a software clear in the same cycle.
		if (reg_wr_i && reg_addr_i == tec_pkg::A_STAT && reg_wdata_i[tec_pkg::STAT_UPD])
		begin
			st_nxt.upd_flag = 1'b0;
		end
		if (upd)
		begin
			st_nxt.upd_flag = 1'b1;
		end

		if (sync_found_i)
		begin
			st_nxt.receive_loss_of_sync = 1'b0;
		end
		if (resync_criteria_i || (wr_cmd && reg_wdata_i[tec_pkg::CMD_RESYNC]))
		begin
			st_nxt.receive_loss_of_sync = 1'b1;
		end

		st_nxt.rdata = 8'h00;
		if (rd_sel)
		begin
			unique case (reg_addr_i)
				tec_pkg::A_CFG:     st_nxt.rdata = st_r.error_counter_config;
				tec_pkg::A_MODE:    st_nxt.rdata = st_r.mode;
				tec_pkg::A_STAT:    st_nxt.rdata = {6'h00, st_r.upd_flag, st_r.receive_loss_of_sync};
				tec_pkg::A_LINE_HI: st_nxt.rdata = st_r.snap[tec_pkg::C_LINE][15:8];
				tec_pkg::A_LINE_LO: st_nxt.rdata = st_r.snap[tec_pkg::C_LINE][7:0];
				tec_pkg::A_PATH_HI: st_nxt.rdata = st_r.snap[tec_pkg::C_PATH][15:8];
				tec_pkg::A_PATH_LO: st_nxt.rdata = st_r.snap[tec_pkg::C_PATH][7:0];
				tec_pkg::A_SYNC_HI: st_nxt.rdata = st_r.snap[tec_pkg::C_SYNC][15:8];
				tec_pkg::A_SYNC_LO: st_nxt.rdata = st_r.snap[tec_pkg::C_SYNC][7:0];
				tec_pkg::A_FEBE_HI: st_nxt.rdata = st_r.snap[tec_pkg::C_FEBE][15:8];
				tec_pkg::A_FEBE_LO: st_nxt.rdata = st_r.snap[tec_pkg::C_FEBE][7:0];
				default:            st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			st_r                      <= '0;
			st_r.error_counter_config <= tec_pkg::CFG_RST;
			st_r.mode                 <= tec_pkg::MODE_RST;
			st_r.receive_loss_of_sync                 <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o            = st_r.rdata;
	assign receive_loss_of_sync_o = st_r.receive_loss_of_sync;
	assign update_flag_o          = st_r.upd_flag;

endmodule
`default_nettype wire

// file: bench/tec_error_counters_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tec_error_counters_monitor
(
	input wire logic       sys_clk_i,
	input wire logic       rstn_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       resync_criteria_i,
	input wire logic       sync_found_i,
	input wire logic       receive_loss_of_sync_o,
	input wire logic       update_flag_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	logic cmd_w;
	logic upd_w;
	logic rsy_w;
	logic clr_w;
	assign cmd_w = reg_wr_i && reg_addr_i == tec_pkg::A_CMD;
	assign upd_w = cmd_w && reg_wdata_i[0];
	assign rsy_w = cmd_w && reg_wdata_i[1];
	assign clr_w = reg_wr_i && reg_addr_i == tec_pkg::A_STAT && reg_wdata_i[1];
	idle_rdata_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not idle");
	cmd_read_a: assert property (reg_rd_i && reg_addr_i == tec_pkg::A_CMD |=> reg_rdata_o == 8'h00)
		else $error("command register read not zero");
	unmapped_read_a: assert property (reg_rd_i && reg_addr_i > tec_pkg::A_FEBE_LO |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	stat_los_a: assert property (reg_rd_i && reg_addr_i == tec_pkg::A_STAT |=> reg_rdata_o[0] == $past(receive_loss_of_sync_o))
		else $error("status loss of sync wrong");
	resync_set_a: assert property (resync_criteria_i || rsy_w |=> receive_loss_of_sync_o)
		else $error("loss of sync not set");
	sync_clear_a: assert property (sync_found_i && !resync_criteria_i && !rsy_w |=> !receive_loss_of_sync_o)
		else $error("loss of sync not cleared");
	los_hold_a: assert property (!(resync_criteria_i || rsy_w || sync_found_i) |=> $stable(receive_loss_of_sync_o))
		else $error("loss of sync changed without cause");
	manual_upd_a: assert property (upd_w |=> update_flag_o)
		else $error("update flag not set");
	flag_clear_a: assert property ($fell(update_flag_o) |-> $past(clr_w))
		else $error("update flag cleared without write");
	flag_hold_a: assert property (update_flag_o && !clr_w |=> update_flag_o)
		else $error("update flag lost without clear");
	cover property (upd_w);
	cover property (rsy_w);
	cover property ($fell(update_flag_o));
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic       clk;
	logic       rstn;
	logic       wr;
	logic       rd;
	logic       bv;
	logic       mk;
	logic       mp;
	logic       sb;
	logic       eb;
	logic       los;
	logic       flg;
	logic [3:0] addr;
	logic [7:0] wd;
	logic [7:0] rdat;
	logic [9:0] ev;
	logic [4:0] lv;
	logic [15:0] v;
	int         n_fail = 0;
	int         checks = 0;
	int         cyc = 0;
	tec_error_counters #(.UPD_SEC_CYC(50), .UPD_T1_CYC(21), .UPD_E1_CYC(31)) DUT
	(
		.sys_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdat), .bit_valid_i(bv), .mark_i(mk), .mark_positive_i(mp), .substitution_bit_i(sb),
		.crc6_error_i(ev[0]), .ft_error_i(ev[1]), .fs_error_i(ev[2]), .fps_error_i(ev[3]),
		.multiframe_tick_i(ev[4]), .crc4_error_i(ev[5]), .fas_word_error_i(ev[6]),
		.fas_sync_lost_i(lv[0]), .crc4_sync_lost_i(lv[1]), .fas_search_i(lv[2]), .cas_mf_search_i(lv[3]),
		.crc4_mf_search_i(lv[4]), .ebit_strobe_i(ev[9]), .ebit_i(eb), .resync_criteria_i(ev[7]),
		.sync_found_i(ev[8]), .receive_loss_of_sync_o(los), .update_flag_o(flg)
	);
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// The saturation fill dominates the run, so the ceiling sits about a third above it.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			n_fail++;
			conclude();
		end
	end
	task conclude;
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr8(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd8(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 d = rdat;
	endtask
	task rd16(input logic [3:0] a, output logic [15:0] r);
		rd8(a, r[15:8]);
		rd8(4'(a + 4'h1), r[7:0]);
	endtask
	task pulse(input int i);
		@(posedge clk);
		ev <= 10'h001 << i;
		@(posedge clk);
		ev <= '0;
	endtask
	task lb(input logic m, input logic p, input logic s, input int n);
		repeat (n)
		begin
			@(posedge clk);
			bv <= 1;
			mk <= m;
			mp <= p;
			sb <= s;
		end
		@(posedge clk);
		bv <= 0;
	endtask
	task upd;
		wr8(tec_pkg::A_CMD, 8'h01);
		@(posedge clk);
	endtask
	task cnts(input logic [15:0] l, input logic [15:0] p, input logic [15:0] s, input logic [15:0] f);
		rd16(tec_pkg::A_LINE_HI, v);
		chk("line", v, l);
		rd16(tec_pkg::A_PATH_HI, v);
		chk("path", v, p);
		rd16(tec_pkg::A_SYNC_HI, v);
		chk("sync", v, s);
		rd16(tec_pkg::A_FEBE_HI, v);
		chk("febe", v, f);
	endtask
	initial
	begin
		{rstn, wr, rd, bv, mk, mp, sb, eb} = '0;
		addr = '0;
		wd = '0;
		ev = '0;
		lv = '0;
		repeat (8) @(posedge clk);
		rstn <= 1;
		repeat (3) @(posedge clk);
		#1 chk("los", los, 1'b1);
		chk("flag", flg, 1'b0);
		rd8(tec_pkg::A_CFG, v[7:0]);
		chk("cfg", v[7:0], tec_pkg::CFG_RST);
		rd8(4'hC, v[7:0]);
		chk("unmapped", v[7:0], 8'h00);
		wr8(tec_pkg::A_CFG, 8'h20);
		lb(1, 1, 0, 1);
		upd();
		lb(1, 0, 0, 1);
		lb(1, 1, 0, 2);
		pulse(1);
		pulse(4);
		pulse(4);
		upd();
		cnts(1, 0, 2, 0);
		pulse(8);
		#1 chk("los", los, 1'b0);
		wr8(tec_pkg::A_CFG, 8'h27);
		pulse(1);
		pulse(2);
		pulse(3);
		pulse(0);
		lb(0, 0, 0, 16);
		lb(1, 0, 0, 1);
		upd();
		cnts(1, 2, 1, 0);
		wr8(tec_pkg::A_MODE, 8'h19);
		wr8(tec_pkg::A_CFG, 8'h20);
		pulse(5);
		pulse(5);
		lv <= 5'h01;
		pulse(5);
		pulse(9);
		lv <= 5'h02;
		pulse(5);
		lv <= 5'h08;
		pulse(5);
		pulse(6);
		lv <= 5'h04;
		pulse(6);
		lv <= 5'h10;
		pulse(6);
		lv <= 5'h00;
		pulse(6);
		pulse(7);
		pulse(6);
		pulse(8);
		pulse(9);
		pulse(9);
		eb <= 1;
		pulse(9);
		lb(1, 1, 0, 1);
		lb(1, 1, 1, 1);
		lb(1, 0, 0, 2);
		upd();
		cnts(1, 3, 1, 2);
		lb(1, 1, 0, 65540);
		upd();
		cnts(16'hFFFF, 0, 0, 0);
		upd();
		cnts(0, 0, 0, 0);
		chk("flag", flg, 1'b1);
		wr8(tec_pkg::A_STAT, 8'h02);
		#1 chk("flag", flg, 1'b0);
		rd8(tec_pkg::A_STAT, v[7:0]);
		chk("stat", v[7:0], 8'h00);
		rd8(tec_pkg::A_CMD, v[7:0]);
		chk("cmd", v[7:0], 8'h00);
		wr8(tec_pkg::A_CMD, 8'h02);
		#1 chk("los", los, 1'b1);
		wr8(tec_pkg::A_CFG, 8'h28);
		upd();
		lb(1, 0, 0, 2);
		lb(1, 1, 0, 3);
		upd();
		cnts(1, 0, 0, 0);
		wr8(tec_pkg::A_MODE, 8'h04);
		wr8(tec_pkg::A_CFG, 8'h21);
		upd();
		lb(0, 0, 0, 8);
		lb(1, 1, 1, 1);
		lb(1, 0, 0, 1);
		upd();
		cnts(1, 0, 0, 0);
		pulse(8);
		wr8(tec_pkg::A_MODE, 8'h02);
		wr8(tec_pkg::A_CFG, 8'h22);
		upd();
		pulse(0);
		pulse(1);
		pulse(3);
		upd();
		cnts(0, 1, 1, 0);
		wr8(tec_pkg::A_CFG, 8'h10);
		upd();
		wr8(tec_pkg::A_STAT, 8'h02);
		repeat (15) @(posedge clk);
		#1 chk("flag", flg, 1'b0);
		repeat (4) @(posedge clk);
		#1 chk("flag", flg, 1'b1);
		conclude();
	end
endmodule
bind tec_error_counters tec_error_counters_monitor MON (.*);
`default_nettype wire
